/* src/mifeb_regs.vh */
// register indices, field layouts, reset values and masks of the interrupt flag bank
// Function
// [RULE_01] pin1 edge code at bits 3..2
// [RULE_02] pin0 edge code at bits 1..0
// [RULE_03] bit 0 of control 0 gates everything; the bank gates only the request with it, wake_o and the vector are not gated
// [RULE_04] control 0 flags 6..4, enables 3..1
// [RULE_05] flag 1 means pending; enable 1 allows
// [RULE_06] control 1 holds group1/group0/low-voltage/serial bits
// [RULE_07] control 2 holds comp1/timebases/group2 bits
// [RULE_08] control 3 holds groups 5..3, bits 7,3 absent
// [RULE_09] unimplemented bits always read zero
// [RULE_10] six group registers with their member sources
// [RULE_11] each timer has P and A match sources
// [RULE_12] external requests only from the two pins
// [RULE_13] disabled pending flag stays, never jumps
// [RULE_14] service entry clears global enable, flags still set
// [RULE_15] any set flag wakes from sleep/idle; the bank wakes only on flags in controls 0 to 3, not on a disabled member flag
// [RULE_16] full stack holds off acknowledge
// [RULE_17] enabled member flag raises its group flag
// [RULE_18] software writes flags; hardware set wins
`ifndef MIFEB_REGS_VH
`define MIFEB_REGS_VH

// register indices on the cpu data-memory port
`define MIFEB_IDX_EDGE 4'h0
`define MIFEB_IDX_CTL0 4'h1
`define MIFEB_IDX_CTL1 4'h2
`define MIFEB_IDX_CTL2 4'h3
`define MIFEB_IDX_CTL3 4'h4
`define MIFEB_IDX_GRP0 4'h5
`define MIFEB_IDX_GRP1 4'h6
`define MIFEB_IDX_GRP2 4'h7
`define MIFEB_IDX_GRP3 4'h8
`define MIFEB_IDX_GRP4 4'h9
`define MIFEB_IDX_GRP5 4'ha

// implemented-bit masks
`define MIFEB_MASK_EDGE 8'h0f
`define MIFEB_MASK_CTL0 8'h7f
`define MIFEB_MASK_CTL1 8'hff
`define MIFEB_MASK_CTL2 8'hff
`define MIFEB_MASK_CTL3 8'h77
`define MIFEB_MASK_GRP_2 8'h33
`define MIFEB_MASK_GRP_3 8'h77

`define MIFEB_RESET_VAL 8'h00

// field positions
`define MIFEB_GLOBAL_EN_BIT 0
`define MIFEB_PIN0_SEL_LSB 0
`define MIFEB_PIN1_SEL_LSB 2
`define MIFEB_EDGE_RISE_BIT 0
`define MIFEB_EDGE_FALL_BIT 1

// number of vectored sources seen by the priority picker
`define MIFEB_NUM_VEC 14

`endif

/* src/mifeb_pin_edge.v */
// external pin synchroniser and edge detector with selectable edge type
`timescale 1ns/10ps
`include "mifeb_regs.vh"

module mifeb_pin_edge (
  input wire clock_i,
  input wire rst_b_i,
  input wire pin_i,
  input wire [1:0] edge_sel_i,
  output reg edge_o
);

  reg sync1;
  reg sync2;
  reg sync3;
  reg level;
  wire change;

  // a change counts only once the second and third stages agree
  assign change = (sync2 == sync3) && (sync2 != level);

  // level starts low, so a pin already high at reset reports one rising edge
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
      if (change) begin
        level <= sync2;
      end
      // code 00 gives no edge at all, 11 gives both
      edge_o <= change & ((sync2 & edge_sel_i[`MIFEB_EDGE_RISE_BIT]) | // [RULE_01] [RULE_02]
                          (~sync2 & edge_sel_i[`MIFEB_EDGE_FALL_BIT]));
    end
  end

endmodule

/* src/mifeb_irq_bank.v */
// interrupt flag and enable bank: registers, group flags, priority and wake-up
`timescale 1ns/10ps
`include "mifeb_regs.vh"

module mifeb_irq_bank (
  input wire clock_i,
  input wire rst_b_i,
  // external pins, asynchronous
  input wire pin0_i,
  input wire pin1_i,
  // single-cycle events from on-chip peripherals
  input wire line_comp0_evt_i,
  input wire line_comp1_evt_i,
  input wire low_voltage_evt_i,
  input wire serial_if_evt_i,
  input wire timebase0_evt_i,
  input wire timebase1_evt_i,
  input wire conversion_done_evt_i,
  input wire nvm_write_evt_i,
  input wire uart0_evt_i,
  input wire uart1_evt_i,
  input wire [1:0] std_timer_p_evt_i,
  input wire [1:0] std_timer_a_evt_i,
  input wire [2:0] per_timer_p_evt_i,
  input wire [2:0] per_timer_a_evt_i,
  // cpu register port
  input wire [3:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // cpu service handshake
  input wire service_ack_i,
  input wire stack_full_i,
  output reg irq_request_o,
  output reg [3:0] irq_vector_o,
  output reg wake_o
);

  reg [7:0] edge_sel;
  reg [7:0] ctl0;
  reg [7:0] ctl1;
  reg [7:0] ctl2;
  reg [7:0] ctl3;
  reg [7:0] grp0;
  reg [7:0] grp1;
  reg [7:0] grp2;
  reg [7:0] grp3;
  reg [7:0] grp4;
  reg [7:0] grp5;
  reg [7:0] next_rdata;
  wire pin0_evt;
  wire pin1_evt;
  wire [5:0] grp_set;
  wire [`MIFEB_NUM_VEC-1:0] pending;
  wire any_pending;
  wire any_flag;
  wire [7:0] ctl0_hw;
  wire [7:0] ctl1_hw;
  wire [7:0] ctl2_hw;
  wire [7:0] ctl3_hw;
  wire [7:0] grp0_hw;
  wire [7:0] grp1_hw;
  wire [7:0] grp2_hw;
  wire [7:0] grp3_hw;
  wire [7:0] grp4_hw;
  wire [7:0] grp5_hw;
  wire [2:0] ctl0_live;
  wire [3:0] ctl1_live;
  wire [3:0] ctl2_live;
  wire [2:0] ctl3_live;
  reg [7:0] next_edge_sel;
  reg [7:0] next_ctl0;
  reg [7:0] next_ctl1;
  reg [7:0] next_ctl2;
  reg [7:0] next_ctl3;
  reg [7:0] next_grp0;
  reg [7:0] next_grp1;
  reg [7:0] next_grp2;
  reg [7:0] next_grp3;
  reg [7:0] next_grp4;
  reg [7:0] next_grp5;

  // new register value: write replaces, hardware set ored on top, absent bits forced low
  function [7:0] upd;
    input [7:0] old;
    input wr;
    input [7:0] wdata;
    input [7:0] set;
    input [7:0] mask;
    begin
      upd = ((wr ? wdata : old) | set) & mask; // [RULE_18] [RULE_09]
    end
  endfunction

  // flags in the high nibble gated by enables in the low nibble
  function [3:0] live;
    input [7:0] r;
    begin
      live = r[7:4] & r[3:0]; // [RULE_05] [RULE_13]
    end
  endfunction

  // lowest set bit wins; index 0 is the highest priority
  function [3:0] pick;
    input [`MIFEB_NUM_VEC-1:0] req;
    integer i;
    begin
      pick = 4'h0;
      for (i = `MIFEB_NUM_VEC - 1; i >= 0; i = i - 1) begin
        if (req[i]) begin
          pick = i[3:0];
        end
      end
    end
  endfunction

  // write strobe aimed at one register index
  function hit;
    input wr;
    input [3:0] addr;
    input [3:0] idx;
    begin
      hit = wr && (addr == idx);
    end
  endfunction

  // only these two instances may raise the external-pin flags
  mifeb_pin_edge u_pin0 (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .pin_i(pin0_i),
    .edge_sel_i(edge_sel[`MIFEB_PIN0_SEL_LSB+1:`MIFEB_PIN0_SEL_LSB]),
    .edge_o(pin0_evt)
  ); // [RULE_12] [RULE_02]

  mifeb_pin_edge u_pin1 (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .pin_i(pin1_i),
    .edge_sel_i(edge_sel[`MIFEB_PIN1_SEL_LSB+1:`MIFEB_PIN1_SEL_LSB]),
    .edge_o(pin1_evt)
  ); // [RULE_12] [RULE_01]

  // group flag rises while any enabled member is pending; a clear re-sets it then
  assign grp_set[0] = |live(grp0); // [RULE_17]
  assign grp_set[1] = |live(grp1); // [RULE_17]
  assign grp_set[2] = |live(grp2); // [RULE_17]
  assign grp_set[3] = |live(grp3); // [RULE_17]
  assign grp_set[4] = |live(grp4); // [RULE_17]
  assign grp_set[5] = |live(grp5); // [RULE_17]

  // enabled pending sources per control register; control 3 bit 3 is a hole, so only three
  assign ctl0_live = ctl0[6:4] & ctl0[3:1]; // [RULE_04]
  assign ctl1_live = live(ctl1); // [RULE_06]
  assign ctl2_live = live(ctl2); // [RULE_07]
  assign ctl3_live = ctl3[6:4] & ctl3[2:0]; // [RULE_08]

  // vectored sources in priority order
  assign pending = {
    ctl3_live,                  // 13..11: groups 5, 4, 3
    ctl2_live,                  // 10..7: comp1, timebase1, timebase0, group2
    ctl1_live,                  // 6..3: group1, group0, low voltage, serial
    ctl0_live                   // 2..0: pin1, pin0, comp0
  }; // [RULE_13]

  assign any_pending = |pending;
  assign any_flag = (|ctl0[6:4]) | (|ctl1[7:4]) | (|ctl2[7:4]) | (|ctl3[6:4]);

  // register file; hardware sets are applied every cycle so they beat a software clear
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      edge_sel <= `MIFEB_RESET_VAL;
      ctl0 <= `MIFEB_RESET_VAL;
      ctl1 <= `MIFEB_RESET_VAL;
      ctl2 <= `MIFEB_RESET_VAL;
      ctl3 <= `MIFEB_RESET_VAL;
      grp0 <= `MIFEB_RESET_VAL;
      grp1 <= `MIFEB_RESET_VAL;
      grp2 <= `MIFEB_RESET_VAL;
      grp3 <= `MIFEB_RESET_VAL;
      grp4 <= `MIFEB_RESET_VAL;
      grp5 <= `MIFEB_RESET_VAL;
    end else begin
      edge_sel <= next_edge_sel;
      ctl0 <= next_ctl0;
      ctl1 <= next_ctl1;
      ctl2 <= next_ctl2;
      ctl3 <= next_ctl3;
      grp0 <= next_grp0;
      grp1 <= next_grp1;
      grp2 <= next_grp2;
      grp3 <= next_grp3;
      grp4 <= next_grp4;
      grp5 <= next_grp5;
    end
  end

  // hardware set patterns, flags in the high nibble; group members: adc and nvm, then the
  // timers' a-match above p-match, uarts on bit 6
  assign ctl0_hw = {1'b0, pin1_evt, pin0_evt, line_comp0_evt_i, 4'h0}; // [RULE_04]
  assign ctl1_hw = {grp_set[1], grp_set[0], low_voltage_evt_i, serial_if_evt_i,
                    4'h0}; // [RULE_06]
  assign ctl2_hw = {line_comp1_evt_i, timebase1_evt_i, timebase0_evt_i, grp_set[2],
                    4'h0}; // [RULE_07]
  assign ctl3_hw = {1'b0, grp_set[5], grp_set[4], grp_set[3], 4'h0}; // [RULE_08]
  assign grp0_hw = {2'b00, nvm_write_evt_i, conversion_done_evt_i, 4'h0}; // [RULE_10]
  assign grp1_hw = {2'b00, per_timer_a_evt_i[0], per_timer_p_evt_i[0],
                    4'h0}; // [RULE_10] [RULE_11]
  assign grp2_hw = {2'b00, std_timer_a_evt_i[0], std_timer_p_evt_i[0],
                    4'h0}; // [RULE_10] [RULE_11]
  assign grp3_hw = {1'b0, uart0_evt_i, std_timer_a_evt_i[1], std_timer_p_evt_i[1],
                    4'h0}; // [RULE_10] [RULE_11]
  assign grp4_hw = {1'b0, uart1_evt_i, per_timer_a_evt_i[1], per_timer_p_evt_i[1],
                    4'h0}; // [RULE_10] [RULE_11]
  assign grp5_hw = {2'b00, per_timer_a_evt_i[2], per_timer_p_evt_i[2],
                    4'h0}; // [RULE_10] [RULE_11]

  // next register values: write replaces, hardware set ored on top so it beats a clear
  always @* begin
    next_edge_sel = upd(edge_sel, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_EDGE),
                        reg_wdata_i, 8'h00, `MIFEB_MASK_EDGE); // [RULE_09]
    next_ctl0 = upd(ctl0, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_CTL0),
                    reg_wdata_i, ctl0_hw, `MIFEB_MASK_CTL0); // [RULE_04]
    next_ctl1 = upd(ctl1, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_CTL1),
                    reg_wdata_i, ctl1_hw, `MIFEB_MASK_CTL1); // [RULE_06]
    next_ctl2 = upd(ctl2, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_CTL2),
                    reg_wdata_i, ctl2_hw, `MIFEB_MASK_CTL2); // [RULE_07]
    next_ctl3 = upd(ctl3, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_CTL3),
                    reg_wdata_i, ctl3_hw, `MIFEB_MASK_CTL3); // [RULE_08]
    next_grp0 = upd(grp0, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_GRP0),
                    reg_wdata_i, grp0_hw, `MIFEB_MASK_GRP_2); // [RULE_10]
    next_grp1 = upd(grp1, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_GRP1),
                    reg_wdata_i, grp1_hw, `MIFEB_MASK_GRP_2); // [RULE_10] [RULE_11]
    next_grp2 = upd(grp2, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_GRP2),
                    reg_wdata_i, grp2_hw, `MIFEB_MASK_GRP_2); // [RULE_10] [RULE_11]
    next_grp3 = upd(grp3, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_GRP3),
                    reg_wdata_i, grp3_hw, `MIFEB_MASK_GRP_3); // [RULE_10] [RULE_11]
    next_grp4 = upd(grp4, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_GRP4),
                    reg_wdata_i, grp4_hw, `MIFEB_MASK_GRP_3); // [RULE_10] [RULE_11]
    next_grp5 = upd(grp5, hit(reg_wr_i, reg_addr_i, `MIFEB_IDX_GRP5),
                    reg_wdata_i, grp5_hw, `MIFEB_MASK_GRP_2); // [RULE_10] [RULE_11]
    // entering service drops the global enable even against a write of one
    if (service_ack_i) begin
      next_ctl0[`MIFEB_GLOBAL_EN_BIT] = 1'b0; // [RULE_14]
    end
  end

  // read mux; unmapped indices answer zero
  always @* begin
    case (reg_addr_i)
      `MIFEB_IDX_EDGE: next_rdata = edge_sel;
      `MIFEB_IDX_CTL0: next_rdata = ctl0;
      `MIFEB_IDX_CTL1: next_rdata = ctl1;
      `MIFEB_IDX_CTL2: next_rdata = ctl2;
      `MIFEB_IDX_CTL3: next_rdata = ctl3;
      `MIFEB_IDX_GRP0: next_rdata = grp0;
      `MIFEB_IDX_GRP1: next_rdata = grp1;
      `MIFEB_IDX_GRP2: next_rdata = grp2;
      `MIFEB_IDX_GRP3: next_rdata = grp3;
      `MIFEB_IDX_GRP4: next_rdata = grp4;
      `MIFEB_IDX_GRP5: next_rdata = grp5;
      default: next_rdata = 8'h00; // [RULE_09]
    endcase
  end

  // read data is captured on the read strobe and held until the next read
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // global enable and free stack space both needed before asking the core; the ack cycle
  // itself is masked because the cleared enable only shows one edge later
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_request_o <= 1'b0;
    end else begin
      irq_request_o <= any_pending & ctl0[`MIFEB_GLOBAL_EN_BIT] & ~stack_full_i
                       & ~service_ack_i; // [RULE_03] [RULE_13] [RULE_16] [RULE_14]
    end
  end

  // vector is registered, so it trails the flags by one cycle like the request
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_vector_o <= 4'h0;
    end else begin
      irq_vector_o <= pick(pending);
    end
  end

  // wake ignores control-register enables: any flag in controls 0 to 3 ends sleep or idle
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= any_flag; // [RULE_15]
    end
  end

endmodule

/* tb/mifeb_irq_bank_chk.sv */
// port assertions for the interrupt flag and enable bank
`timescale 1ns/10ps
module mifeb_irq_bank_chk (
  input wire clock_i,
  input wire rst_b_i,
  input wire [3:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire service_ack_i,
  input wire stack_full_i,
  input wire irq_request_o,
  input wire wake_o
);
  // one domain, so clock and reset are given once
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  chk_ack_blocks: assert property (service_ack_i |=> !irq_request_o [*2])
    else $error("request seen after service entry");
  chk_stack_holds: assert property (stack_full_i |=> !irq_request_o)
    else $error("request while stack full");
  chk_wake_covers: assert property (irq_request_o |-> wake_o)
    else $error("request without wake");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 4'ha |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_edge_upper: assert property (reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o[7:4] == 4'h0)
    else $error("edge select upper bits set");
  chk_ctl3_holes: assert property (reg_rd_i && reg_addr_i == 4'h4 |=> !reg_rdata_o[7] && !reg_rdata_o[3])
    else $error("control 3 hole bits set");
  chk_ctl0_top: assert property (reg_rd_i && reg_addr_i == 4'h1 |=> !reg_rdata_o[7])
    else $error("control 0 bit 7 set");
  chk_edge_rdback: assert property (reg_wr_i && reg_addr_i == 4'h0 ##1 reg_rd_i && reg_addr_i == 4'h0
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h0f))
    else $error("edge select read back wrong");
endmodule
bind mifeb_irq_bank mifeb_irq_bank_chk u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .service_ack_i(service_ack_i), .stack_full_i(stack_full_i),
  .irq_request_o(irq_request_o), .wake_o(wake_o));

/* tb/mifeb_src_model.sv */
// peripheral event sources: one pulse line at a time
`timescale 1ns/10ps
module mifeb_src_model (
  input wire [4:0] sel_i,
  output wire [19:0] evt_o
);
  // zero means quiet; a select held one cycle gives a one-cycle hardware set
  assign evt_o = (sel_i == 5'h00) ? 20'h00000 : (20'h00001 << (sel_i - 5'h01));
endmodule

/* tb/mifeb_irq_bank_bench.sv */
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/10ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin num_errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, x); end end
module mifeb_irq_bank_bench;
  localparam [79:0] TA = 80'ha96a9687879855332231;
  localparam [79:0] TB = 80'h55544455446654654574;
  reg clock_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg wr = 1'b0, rd = 1'b0, ack = 1'b0, full = 1'b0, rd_q = 1'b0;
  reg [1:0] pins = 2'b00;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00, r8, e;
  reg [4:0] sel = 5'h00;
  reg [7:0] exp_q[$];
  wire [19:0] evt;
  wire [7:0] rdata;
  wire [3:0] vec;
  wire irq, wake;
  integer num_errors = 0, total_checks = 0, cycles = 0, seed = 16, i, k;
  always #4 clock_i = ~clock_i;
  mifeb_src_model SRC (.sel_i(sel), .evt_o(evt));
  mifeb_irq_bank DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .pin0_i(pins[0]), .pin1_i(pins[1]),
    .line_comp0_evt_i(evt[0]), .line_comp1_evt_i(evt[1]), .low_voltage_evt_i(evt[2]),
    .serial_if_evt_i(evt[3]), .timebase0_evt_i(evt[4]), .timebase1_evt_i(evt[5]),
    .conversion_done_evt_i(evt[6]), .nvm_write_evt_i(evt[7]), .uart0_evt_i(evt[8]),
    .uart1_evt_i(evt[9]), .std_timer_p_evt_i(evt[11:10]), .std_timer_a_evt_i(evt[13:12]),
    .per_timer_p_evt_i(evt[16:14]), .per_timer_a_evt_i(evt[19:17]), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .service_ack_i(ack), .stack_full_i(full), .irq_request_o(irq), .irq_vector_o(vec),
    .wake_o(wake));
  // read data lands one edge after the strobe, so it is judged mid-cycle
  always @(posedge clock_i) rd_q <= rd;
  always @(negedge clock_i) if (rd_q) begin
    e = exp_q.pop_front();
    `CHK(rdata, e)
  end
  // hang guard, far above the roughly 300 cycles the sequence needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report;
    end
  end
  task final_report;
    begin
      if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // one cycle of the cpu port and event select; reads note their expectation
  task acc(input w, input r, input [3:0] a, input [7:0] d, input [4:0] s, input [7:0] x);
    begin
      {wr, rd, addr, wdata, sel} = {w, r, a, d, s};
      if (r) exp_q.push_back(x);
      @(negedge clock_i);
    end
  endtask
  task idle(input integer n);
    repeat (n) acc(0, 0, 0, 0, 0, 0);
  endtask
  // implemented bits of each index, zero where nothing is mapped
  function [7:0] msk(input [3:0] a);
    msk = (a == 4'h0) ? 8'h0f : (a == 4'h1) ? 8'h7f : (a < 4'h4) ? 8'hff :
      (a == 4'h4 || a == 4'h8 || a == 4'h9) ? 8'h77 : (a < 4'hb) ? 8'h33 : 8'h00;
  endfunction
  initial begin
    repeat (10) @(negedge clock_i);
    rst_b_i = 1'b1;
    @(negedge clock_i);
    for (i = 0; i < 16; i++) acc(0, 1, i, 0, 0, 8'h00);
    // random values back through the masks; groups cleared before controls
    for (i = 0; i < 16; i++) begin
      r8 = $random(seed);
      acc(1, 0, i, r8, 0, 0);
      acc(0, 1, i, 0, 0, r8 & msk(i));
    end
    for (i = 15; i >= 0; i--) acc(1, 0, i, 0, 0, 0);
    // each source sets its own bit while every enable is off
    for (i = 0; i < 20; i++) begin
      acc(0, 0, 0, 0, i + 1, 0);
      acc(0, 1, TA[i*4+:4], 0, 0, 8'h01 << TB[i*4+:4]);
      acc(1, 0, TA[i*4+:4], 0, 0, 0);
    end
    // each edge code on each pin, rising then falling
    for (k = 0; k < 8; k++) begin
      acc(1, 0, 4'h0, (k & 3) << (2 * (k >> 2)), 0, 0);
      pins = 2'b01 << (k >> 2);
      idle(6);
      acc(0, 1, 4'h1, 0, 0, (k & 1) << (5 + (k >> 2)));
      acc(1, 0, 4'h1, 0, 0, 0);
      pins = 2'b00;
      idle(6);
      acc(0, 1, 4'h1, 0, 0, ((k >> 1) & 1) << (5 + (k >> 2)));
      acc(1, 0, 4'h1, 0, 0, 0);
    end
    // member through group to request, then stack full and service entry
    acc(1, 0, 4'h5, 8'h01, 0, 0);
    acc(1, 0, 4'h2, 8'h04, 0, 0);
    acc(1, 0, 4'h1, 8'h01, 7, 0);
    idle(3);
    `CHK({irq, vec, wake}, 6'h2b)
    full = 1'b1;
    idle(2);
    `CHK(irq, 1'b0)
    full = 1'b0;
    idle(2);
    ack = 1'b1;
    idle(1);
    ack = 1'b0;
    idle(2);
    `CHK(irq, 1'b0)
    acc(0, 1, 4'h1, 0, 0, 8'h00);
    acc(0, 1, 4'h5, 0, 0, 8'h11);
    acc(0, 1, 4'h2, 0, 0, 8'h44);
    acc(1, 0, 4'h5, 0, 0, 0);
    acc(1, 0, 4'h2, 0, 0, 0);
    // hardware set beats a clearing write; then enable and global gating
    acc(1, 0, 4'h1, 8'h00, 1, 0);
    acc(0, 1, 4'h1, 0, 0, 8'h10);
    acc(1, 0, 4'h1, 8'h11, 0, 0);
    idle(2);
    `CHK({irq, wake}, 2'b01)
    acc(1, 0, 4'h1, 8'h13, 0, 0);
    idle(2);
    `CHK({irq, vec}, 5'h10)
    acc(1, 0, 4'h1, 8'h12, 0, 0);
    idle(2);
    `CHK(irq, 1'b0)
    // two enabled sources at once: the lower index wins, the other follows once cleared
    acc(1, 0, 4'h3, 8'h44, 0, 0);
    acc(1, 0, 4'h1, 8'h13, 0, 0);
    idle(2);
    `CHK({irq, vec}, 5'h10)
    acc(1, 0, 4'h1, 8'h03, 0, 0);
    idle(2);
    `CHK({irq, vec}, 5'h19)
    final_report;
  end
endmodule
